// ### spcfg_pkg.sv
// Constants, register map and types shared by the serial configuration port.
// Assumes a 13-bit register address space reached by 16-bit instructions.
package spcfg_pkg;
	// Register addresses
	localparam logic [12:0] A_SETUP = 13'h000;
	localparam logic [12:0] A_ID = 13'h003;
	localparam logic [12:0] A_RBSEL = 13'h004;
	localparam logic [12:0] A_DIV = 13'h1e0;
	localparam logic [12:0] A_CLKIN = 13'h1e1;
	localparam logic [12:0] A_PDSYNC = 13'h230;
	localparam logic [12:0] A_RSVD = 13'h231;
	localparam logic [12:0] A_UPD = 13'h232;
	localparam logic [12:0] ADDR_STEP = 13'h001;

	// Values after reset and writable masks
	localparam logic [7:0] SETUP_RST = 8'h18;
	localparam logic [7:0] SRST_MASK = 8'h04;
	localparam logic [7:0] DIV_RST = 8'h02;
	localparam logic [7:0] CLKIN_RST = 8'h00;
	localparam logic [7:0] PDSYNC_RST = 8'h00;
	localparam logic [7:0] DIV_MASK = 8'h07;
	localparam logic [7:0] CLKIN_MASK = 8'h1f;
	localparam logic [7:0] PDSYNC_MASK = 8'h07;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// Arbitrary variant code, not tied to any real part
	localparam logic [7:0] VARIANT_ID = 8'h5a;

	// Field positions
	localparam int SETUP_LONG_BIT = 3;
	localparam int SETUP_SRST_BIT = 2;
	localparam int SETUP_LSB_BIT = 1;
	localparam int SETUP_TWOPIN_BIT = 0;
	localparam int UPD_BIT = 0;
	localparam int RBSEL_BIT = 0;
	localparam int RW_BIT = 15;
	localparam int CNT_HI = 14;
	localparam int CNT_LO = 13;

	// Frame counts
	localparam logic [4:0] INSTR_BITS = 5'h10;
	localparam logic [4:0] BYTE_BITS = 5'h08;
	localparam logic [1:0] CNT_STREAM = 2'h3;

	typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_DATA, ST_HOLD} port_state_e;
endpackage : spcfg_pkg

// ### sp_if.sv
// Carrier between pin edge detector, frame controller and register bank.
// Assumes all three share one clock.
`timescale 1ns/1ns
interface sp_if;
	logic sclk_rise;
	logic sclk_fall;
	logic frame_start;
	logic frame_end;
	logic din;
	logic wr;
	logic [12:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [7:0] setup;

	modport edge_mp (output sclk_rise, sclk_fall, frame_start, frame_end, din);
	modport bank_mp (input wr, addr, wdata, output rdata, setup);
	modport ctl_mp (input sclk_rise, sclk_fall, frame_start, frame_end, din,
		input rdata, setup, output wr, addr, wdata);
endinterface : sp_if

// ### pin_edges.sv
// Edge and frame detection on the serial port pins.
// Assumes pins are synchronous to clk and serial clock phases last at least two clocks.
`timescale 1ns/1ns
module pin_edges
	import spcfg_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Serial pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdio_i,
	// Events
	sp_if.edge_mp ev
);
	typedef struct packed {
		logic sclk;
		logic cs_n;
	} pins_s;

	pins_s q, d;

	// Previous pin levels
	always_comb begin
		d.sclk = sclk;
		d.cs_n = cs_n;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '{sclk: 1'b1, cs_n: 1'b1}; // Idle pin levels, so reset gives no false edge
		end else begin
			q <= d;
		end
	end

	// Edges count only inside a frame
	assign ev.sclk_rise = sclk & ~q.sclk & ~cs_n;
	assign ev.sclk_fall = ~sclk & q.sclk & ~cs_n;
	assign ev.frame_start = q.cs_n & ~cs_n;
	assign ev.frame_end = ~q.cs_n & cs_n;
	assign ev.din = sdio_i;
endmodule : pin_edges

// ### config_bank.sv
// Buffer and active register copies, update-all and soft reset.
// Assumes one-cycle write strobes from the frame controller.
`timescale 1ns/1ns
module config_bank
	import spcfg_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register access
	sp_if.bank_mp b,
	// Active settings
	output logic [7:0] div_active,
	output logic [7:0] clkin_active,
	output logic [7:0] pdsync_active
);
	typedef struct packed {
		logic [7:0] setup;
		logic rbsel;
		logic [7:0] div_b;
		logic [7:0] clkin_b;
		logic [7:0] pd_b;
		logic [7:0] div_a;
		logic [7:0] clkin_a;
		logic [7:0] pd_a;
		logic upd;
	} bank_s;

	localparam bank_s BANK_RST = '{setup: SETUP_RST, rbsel: 1'b0,
		div_b: DIV_RST, clkin_b: CLKIN_RST, pd_b: PDSYNC_RST,
		div_a: DIV_RST, clkin_a: CLKIN_RST, pd_a: PDSYNC_RST, upd: 1'b0};

	bank_s q, d;

	// Copy first, then writes, so a new update request wins over the clear
	always_comb begin
		d = q;
		if (q.upd) begin
			d.div_a = q.div_b; // R9
			d.clkin_a = q.clkin_b; // R9
			d.pd_a = q.pd_b; // R9
			d.upd = 1'b0; // R8
		end
		if (b.wr) begin
			case (b.addr)
				A_SETUP: d.setup = b.wdata;
				A_RBSEL: d.rbsel = b.wdata[RBSEL_BIT]; // R7
				A_DIV: d.div_b = b.wdata & DIV_MASK; // R9 R10
				A_CLKIN: d.clkin_b = b.wdata & CLKIN_MASK; // R9 R10
				A_PDSYNC: d.pd_b = b.wdata & PDSYNC_MASK; // R9 R10
				A_UPD: d.upd = q.upd | b.wdata[UPD_BIT] | d.upd; // R8
				default: ; // R6 R10
			endcase
		end
		// Held at defaults until software writes the bit back to zero
		if (d.setup[SETUP_SRST_BIT]) begin
			d = BANK_RST; // R3
			d.setup = SETUP_RST | SRST_MASK; // R3
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= BANK_RST; // R2 R4 R5 R7
		end else begin
			q <= d;
		end
	end

	// Readback mux, unmapped bytes read zero
	always_comb begin
		case (b.addr)
			A_SETUP: b.rdata = q.setup;
			A_ID: b.rdata = VARIANT_ID; // R6
			A_RBSEL: b.rdata = {7'h00, q.rbsel};
			A_DIV: b.rdata = q.rbsel ? q.div_a : q.div_b; // R7
			A_CLKIN: b.rdata = q.rbsel ? q.clkin_a : q.clkin_b; // R7
			A_PDSYNC: b.rdata = q.rbsel ? q.pd_a : q.pd_b; // R7
			A_UPD: b.rdata = {7'h00, q.upd};
			default: b.rdata = BYTE_ZERO; // R10
		endcase
	end

	assign b.setup = q.setup;
	assign div_active = q.div_a;
	assign clkin_active = q.clkin_a;
	assign pdsync_active = q.pd_a;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	upd_self_clear_a: assert property ((q.upd && !b.wr) |=> !q.upd) // R8
		else $error("update bit did not clear");
	upd_copy_a: assert property ((q.upd && !d.setup[SETUP_SRST_BIT]) |=>
		(q.div_a == $past(q.div_b) && q.pd_a == $past(q.pd_b))) // R9
		else $error("update did not copy buffers");
	buffer_only_a: assert property ((b.wr && !q.upd && !d.setup[SETUP_SRST_BIT])
		|=> $stable(q.clkin_a) && $stable(q.div_a)) // R9
		else $error("write reached active copy");
	soft_reset_a: assert property (q.setup[SETUP_SRST_BIT] |->
		(q.div_b == DIV_RST && q.div_a == DIV_RST && !q.rbsel && !q.upd)) // R3
		else $error("soft reset did not restore defaults");
	id_read_a: assert property ((b.addr == A_ID) |-> (b.rdata == VARIANT_ID)) // R6
		else $error("variant code wrong");
	rsvd_zero_a: assert property ((b.addr == A_RSVD) |-> (b.rdata == BYTE_ZERO)) // R10
		else $error("reserved byte not zero");
	rb_active_a: assert property ((q.rbsel && b.addr == A_PDSYNC) |->
		(b.rdata == q.pd_a)) // R7
		else $error("readback not from active copy");
endmodule : config_bank

// ### serial_port_config_regs.sv
// Serial control port of the clock generator with its configuration registers.
// Assumes the host drives sclk and cs_n synchronous to clk, each sclk phase
// lasting at least two clk cycles, and always sends 16-bit instructions.
//
// Notes on behaviour
// R1: Host writes setup bits 7:4 as bit-reversed copy of bits 3:0.
// R2: Instruction-length bit resets to 1; only 16-bit instructions are decoded.
// R3: Soft reset bit set holds all registers at defaults until written back to 0.
// R4: Bit order 0 means MSB first, address down; 1 means LSB first, address up.
// R5: Data mode 0 uses the data pin both ways; 1 reads on the serial out pin.
// R6: Read-only identification byte returns a fixed variant code; writes ignored.
// R7: Readback select 0 returns buffer registers, 1 returns active registers.
// R8: Update-all bit clears itself after the host sets it.
// R9: Writes land in buffers; update-all copies buffers into the active set.
// R10: Reserved bits and addresses read zero and ignore writes.
`timescale 1ns/1ns
module serial_port_config_regs
	import spcfg_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Serial clock and chip select from the host
	input wire logic sclk,
	input wire logic cs_n,
	// Bidirectional data pin
	input wire logic sdio_i,
	output logic sdio_o,
	output logic sdio_oe_n,
	// Separate serial output pin
	output logic serial_out_pin,
	output logic serial_out_oe_n,
	// Active settings for the clock path
	output logic [7:0] div_active,
	output logic [7:0] clkin_active,
	output logic [7:0] pdsync_active,
	// Serial port mode
	output logic two_pin_data_select,
	output logic lsb_first
);
	typedef struct packed {
		port_state_e st;
		logic [4:0] cnt;
		logic [15:0] sr;
		logic [12:0] addr;
		logic [12:0] waddr;
		logic [1:0] left;
		logic stream;
		logic rw;
		logic [7:0] tx;
		logic reload;
		logic dout;
		logic drive;
		logic wr;
		logic [7:0] wdata;
	} ctl_s;

	localparam ctl_s CTL_RST = '{st: ST_IDLE, cnt: 5'h00, sr: 16'h0000,
		addr: 13'h0000, waddr: 13'h0000, left: 2'h0, stream: 1'b0,
		rw: 1'b0, tx: 8'h00, reload: 1'b0, dout: 1'b0, drive: 1'b0,
		wr: 1'b0, wdata: 8'h00};

	sp_if sp ();

	ctl_s q, d;
	logic lsb;
	logic twopin;
	logic byte_end;
	logic next_bit;

	// Pin edges and frame boundaries
	pin_edges u_edges (
		.clk(clk),
		.rst(rst),
		.sclk(sclk),
		.cs_n(cs_n),
		.sdio_i(sdio_i),
		.ev(sp.edge_mp)
	);

	// Register storage
	config_bank u_bank (
		.clk(clk),
		.rst(rst),
		.b(sp.bank_mp),
		.div_active(div_active),
		.clkin_active(clkin_active),
		.pdsync_active(pdsync_active)
	);

	// Port modes act at once so the host can talk in the new order
	assign lsb = sp.setup[SETUP_LSB_BIT];
	assign twopin = sp.setup[SETUP_TWOPIN_BIT];
	assign byte_end = (q.st == ST_DATA) && sp.sclk_rise && (q.cnt == BYTE_BITS - 5'h01);

	// Frame controller: instruction, data bytes, then hold until deselect unless streaming
	always_comb begin
		d = q;
		d.wr = 1'b0;
		d.reload = 1'b0;
		if (q.reload) begin
			d.tx = sp.rdata; // R7
		end
		if (sp.frame_end) begin
			d.st = ST_IDLE;
			d.drive = 1'b0;
		end else begin
			unique case (q.st)
				ST_IDLE: begin
					if (sp.frame_start) begin
						d.st = ST_INSTR;
						d.cnt = 5'h00;
					end
				end
				ST_INSTR: begin
					if (sp.sclk_rise) begin
						// LSB first fills from the top, so the word lands alike
						d.sr = lsb ? {sp.din, q.sr[15:1]} : {q.sr[14:0], sp.din}; // R4
						d.cnt = q.cnt + 5'h01;
						if (q.cnt == INSTR_BITS - 5'h01) begin // R2
							d.st = ST_DATA;
							d.cnt = 5'h00;
							d.rw = d.sr[RW_BIT];
							d.left = d.sr[CNT_HI:CNT_LO];
							d.stream = (d.sr[CNT_HI:CNT_LO] == CNT_STREAM);
							d.addr = d.sr[12:0];
							d.reload = d.sr[RW_BIT];
						end
					end
				end
				ST_DATA: begin
					// Read bits leave on the falling edge for the host to sample
					if (q.rw && sp.sclk_fall) begin
						d.dout = lsb ? q.tx[0] : q.tx[7]; // R4
						d.tx = lsb ? {1'b0, q.tx[7:1]} : {q.tx[6:0], 1'b0};
						d.drive = 1'b1;
					end
					if (!q.rw && sp.sclk_rise) begin
						d.sr[7:0] = lsb ? {sp.din, q.sr[7:1]} : {q.sr[6:0], sp.din}; // R4
					end
					if (sp.sclk_rise) begin
						d.cnt = q.cnt + 5'h01;
					end
					if (byte_end) begin
						d.cnt = 5'h00;
						d.wr = ~q.rw; // R9
						d.wdata = d.sr[7:0];
						d.waddr = q.addr;
						d.addr = lsb ? q.addr + ADDR_STEP : q.addr - ADDR_STEP; // R4
						d.reload = q.rw;
						if (!q.stream && q.left == 2'h0) begin
							d.st = ST_HOLD;
						end else if (!q.stream) begin
							d.left = q.left - 2'h1;
						end
					end
				end
				ST_HOLD: begin
					// Extra bits past the byte count are ignored
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= CTL_RST;
		end else begin
			q <= d;
		end
	end

	// Bank access: write strobe uses the address held for that byte
	assign sp.wr = q.wr;
	assign sp.wdata = q.wdata;
	assign sp.addr = q.wr ? q.waddr : q.addr;

	// Pin drivers, enables low while driving
	assign sdio_o = q.dout;
	assign serial_out_pin = q.dout;
	assign sdio_oe_n = ~(q.drive & ~twopin); // R5
	assign serial_out_oe_n = ~(q.drive & twopin); // R5
	assign two_pin_data_select = twopin;
	assign lsb_first = lsb;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence instr_done_s;
		(q.st == ST_INSTR) && sp.sclk_rise && !sp.frame_end;
	endsequence

	sequence write_byte_s;
		byte_end && !q.rw && !sp.frame_end;
	endsequence

	// Steps of a read bit and of a completed byte
	sequence read_fall_s;
		(q.st == ST_DATA) && q.rw && sp.sclk_fall;
	endsequence

	sequence last_byte_s;
		byte_end && !q.stream && (q.left == 2'h0);
	endsequence

	sequence more_bytes_s;
		byte_end && (q.stream || (q.left != 2'h0));
	endsequence

	long_reset_a: assert property ($fell(rst) |-> sp.setup[SETUP_LONG_BIT]) // R2
		else $error("long instruction bit not set after reset");
	instr_len_a: assert property ((instr_done_s and (q.cnt == INSTR_BITS - 5'h01))
		|=> (q.st == ST_DATA && q.cnt == 5'h00)) // R2
		else $error("instruction not ended after sixteen bits");
	instr_early_a: assert property ((instr_done_s and (q.cnt < INSTR_BITS - 5'h01))
		|=> (q.st == ST_INSTR)) // R2
		else $error("instruction ended early");
	addr_step_a: assert property ((byte_end && !sp.frame_end) |=>
		(q.addr == ($past(lsb) ? $past(q.addr) + ADDR_STEP
		: $past(q.addr) - ADDR_STEP))) // R4
		else $error("address step wrong for bit order");
	write_strobe_a: assert property (write_byte_s |=> (sp.wr && sp.addr == $past(q.addr))
		##1 !sp.wr) // R9
		else $error("write strobe missing or misaddressed");
	pin_mode_a: assert property ((!twopin |-> serial_out_oe_n) and
		(twopin |-> sdio_oe_n)) // R5
		else $error("wrong pin driven for data mode");
	read_load_a: assert property (q.reload |=> (q.tx == $past(sp.rdata))) // R7
		else $error("read byte not loaded");

	// Bit the next falling edge must present, for the checks below
	assign next_bit = lsb ? q.tx[0] : q.tx[7];

	// Frame boundaries and the hold state
	idle_wait_a: assert property ((q.st == ST_IDLE && !sp.frame_start) |=>
		(q.st == ST_IDLE))
		else $error("left idle without a frame start");
	frame_go_a: assert property ((q.st == ST_IDLE && sp.frame_start) |=>
		(q.st == ST_INSTR && q.cnt == 5'h00))
		else $error("frame start not taken");
	frame_abort_a: assert property (sp.frame_end |=>
		(q.st == ST_IDLE && !q.drive)) // R5
		else $error("deselect did not end the frame");
	hold_ignore_a: assert property ((q.st == ST_HOLD && !sp.frame_end) |=>
		(q.st == ST_HOLD && !q.wr))
		else $error("bits past the byte count were taken");

	// Instruction shift, decode and bit counters
	shift_msb_a: assert property ((instr_done_s and !lsb) |=>
		(q.sr[0] == $past(sp.din))) // R4
		else $error("msb first bit not shifted in at the bottom");
	shift_lsb_a: assert property ((instr_done_s and lsb) |=>
		(q.sr[15] == $past(sp.din))) // R4
		else $error("lsb first bit not shifted in at the top");
	instr_decode_a: assert property ((instr_done_s and (q.cnt == INSTR_BITS - 5'h01)) |=>
		(q.addr == q.sr[12:0] && q.rw == q.sr[RW_BIT])) // R2
		else $error("instruction fields not decoded");
	stream_flag_a: assert property ((instr_done_s and (q.cnt == INSTR_BITS - 5'h01)) |=>
		(q.stream == (q.left == CNT_STREAM)))
		else $error("stream count not decoded");
	instr_bound_a: assert property ((q.st == ST_INSTR) |-> (q.cnt < INSTR_BITS)) // R2
		else $error("instruction bit count out of range");
	data_bound_a: assert property ((q.st == ST_DATA) |-> (q.cnt < BYTE_BITS))
		else $error("data bit count out of range");

	// Byte count, stream mode, next-byte requests, address hold and write strobe
	last_byte_a: assert property (last_byte_s |=> (q.st == ST_HOLD))
		else $error("byte count not honoured");
	more_bytes_a: assert property (more_bytes_s |=> (q.st == ST_DATA && q.cnt == 5'h00))
		else $error("frame stopped before its byte count");
	left_count_a: assert property ((more_bytes_s and !q.stream) |=>
		(q.left == $past(q.left) - 2'h1))
		else $error("byte count not decremented");
	stream_keep_a: assert property ((more_bytes_s and q.stream) |=>
		(q.left == $past(q.left)))
		else $error("stream count changed");
	read_next_a: assert property ((byte_end && q.rw) |=>
		q.reload) // R7
		else $error("next read byte not requested");
	addr_hold_a: assert property ((q.st == ST_DATA && !byte_end) |=>
		$stable(q.addr)) // R4
		else $error("address moved inside a byte");
	wr_pulse_a: assert property (sp.wr |=> !sp.wr) // R9
		else $error("write strobe longer than one cycle");
	reload_pulse_a: assert property (q.reload |=>
		!q.reload) // R7
		else $error("read reload longer than one cycle");
	wdata_match_a: assert property (write_byte_s |=>
		(sp.wdata == q.sr[7:0])) // R9
		else $error("written byte differs from shifted byte");

	// Read bits and pin enables
	read_bit_a: assert property (read_fall_s |=>
		(q.dout == $past(next_bit) && q.drive)) // R4
		else $error("read bit not presented after falling edge");
	read_stand_a: assert property ((q.st == ST_DATA && q.rw && !sp.sclk_fall) |=>
		$stable(q.dout)) // R5
		else $error("read bit changed between falling edges");
	drive_hold_a: assert property ((q.drive && !sp.frame_end) |=> q.drive) // R5
		else $error("data pin released inside a read");
	drive_pin_a: assert property (q.drive |-> (twopin ? !serial_out_oe_n : !sdio_oe_n)) // R5
		else $error("selected read pin not driven");
	pins_quiet_a: assert property ((!q.rw || q.st == ST_IDLE || q.st == ST_INSTR) |->
		(sdio_oe_n && serial_out_oe_n)) // R5
		else $error("pin driven outside a read");
endmodule : serial_port_config_regs

// ### host_model.sv
// Host controller model that drives the serial control port frames.
// Assumes the tb resolves the data line and returns the level seen by the host.
`timescale 1ns/1ns
module host_model (
	// Clock
	input wire logic clk,
	// Pins driven by the host
	output logic sclk,
	output logic cs_n,
	output logic data_out,
	// Level seen on the host's read pin
	input wire logic line_in
);
	// Serial clock stands high between frames
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		data_out = 1'b0;
	end

	// One bit: three clocks low, sampled after the second, then three clocks high
	task automatic bit_x(input logic b, output logic s);
		@(posedge clk) sclk <= 1'b0;
		data_out <= b;
		repeat (2) @(posedge clk);
		s = line_in;
		@(posedge clk) sclk <= 1'b1;
		repeat (2) @(posedge clk);
	endtask : bit_x

	// Whole frame; on reads the host toggles its released pin every bit
	task automatic xfer(input logic rd, input logic [1:0] n, input logic [12:0] a,
		input logic lsb, input logic [31:0] d, output logic [31:0] q);
		logic [15:0] w;
		logic s;
		int k;
		w = {rd, n, a};
		q = 32'h0;
		@(posedge clk) cs_n <= 1'b0;
		for (int i = 0; i < 16; i++) bit_x(w[lsb ? i : 15 - i], s);
		for (int j = 0; j < 8 * (n + 1); j++) begin
			k = 8 * (j / 8) + (lsb ? j % 8 : 7 - j % 8);
			bit_x(rd ? ~data_out : d[k], s);
			q[k] = s;
		end
		@(posedge clk) cs_n <= 1'b1;
		repeat (2) @(posedge clk);
	endtask : xfer
endmodule : host_model

// ### tb_top.sv
// Self-checking bench for the serial configuration register block.
// Assumes host_model is compiled first and frames follow the port contract.
`timescale 1ns/1ns
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module tb_top
	import spcfg_pkg::*;
;
	logic clk, rst, sclk, cs_n, hd, hin, sdio_o, sdio_oe_n, so, so_oe_n, two_pin, lsb_q;
	logic sdio_w, lsb_mode;
	logic [7:0] div_a, clkin_a, pd_a;
	int n_checks = 0;
	int n_mismatch = 0;

	// Data pin resolved from sdio_oe_n alone; host reads whichever pin is driven
	assign sdio_w = !sdio_oe_n ? sdio_o : hd;
	assign hin = !so_oe_n ? so : sdio_w;

	serial_port_config_regs DUT (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
		.sdio_i(sdio_w), .sdio_o(sdio_o), .sdio_oe_n(sdio_oe_n), .serial_out_pin(so),
		.serial_out_oe_n(so_oe_n), .div_active(div_a), .clkin_active(clkin_a),
		.pdsync_active(pd_a), .two_pin_data_select(two_pin), .lsb_first(lsb_q));

	host_model h (.clk(clk), .sclk(sclk), .cs_n(cs_n), .data_out(hd), .line_in(hin));

	// Clock at 250 MHz
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Both output pins driven at once would fight on the board
	always @(posedge clk) begin
		if (!rst && sdio_oe_n === 1'b0 && so_oe_n === 1'b0) `CHK("one_pin", 1'b1, 1'b0)
	end

	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out

	task automatic wr(input logic [12:0] a, input logic [1:0] n, input logic [31:0] d);
		logic [31:0] q;
		h.xfer(1'b0, n, a, lsb_mode, d, q);
	endtask : wr

	task automatic rd_chk(input string nm, input logic [12:0] a, input logic [1:0] n,
		input logic [31:0] e);
		logic [31:0] q;
		h.xfer(1'b1, n, a, lsb_mode, 32'h0, q);
		`CHK(nm, e, q)
	endtask : rd_chk

	// Watchdog well above the roughly 5300 clocks the sequence needs
	initial begin
		#200000;
		n_mismatch++;
		close_out();
	end

	// Main sequence
	initial begin
		rst = 1'b1;
		lsb_mode = 1'b0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		`CHK("div_rst", DIV_RST, div_a)
		`CHK("order_rst", 1'b0, lsb_q)
		`CHK("mode_rst", 1'b0, two_pin)
		rd_chk("setup_rst", A_SETUP, 2'h0, 32'h18);
		wr(A_ID, 2'h0, 32'hff);
		rd_chk("id", A_ID, 2'h0, {24'h0, VARIANT_ID});
		rd_chk("rbsel_rst", A_RBSEL, 2'h0, 32'h0);
		wr(A_DIV, 2'h0, 32'h05);
		`CHK("div_held", DIV_RST, div_a)
		rd_chk("div_buf", A_DIV, 2'h0, 32'h05);
		wr(A_RBSEL, 2'h0, 32'h01);
		rd_chk("div_act", A_DIV, 2'h0, 32'h02);
		wr(A_UPD, 2'h0, 32'h01);
		`CHK("div_upd", 8'h05, div_a)
		rd_chk("upd_clr", A_UPD, 2'h0, 32'h0);
		wr(A_RBSEL, 2'h0, 32'h0);
		wr(A_RSVD, 2'h0, 32'hff);
		rd_chk("rsvd", A_RSVD, 2'h0, 32'h0);
		rd_chk("unmapped", 13'h100, 2'h0, 32'h0);
		// Two bytes, address stepping down, reserved bits masked
		wr(A_CLKIN, 2'h1, 32'h03ff);
		rd_chk("msb_pair", A_CLKIN, 2'h1, 32'h031f);
		wr(A_SETUP, 2'h0, 32'h5a);
		lsb_mode = 1'b1;
		`CHK("lsb_on", 1'b1, lsb_q)
		wr(A_DIV, 2'h1, 32'h0a04);
		rd_chk("lsb_pair", A_DIV, 2'h1, 32'h0a04);
		// Stream runs past the mapped bytes; three-byte read back
		wr(A_DIV, 2'h3, 32'h77661e03);
		rd_chk("stream_rd", A_DIV, 2'h2, 32'h001e03);
		wr(A_PDSYNC, 2'h0, 32'hff);
		wr(A_UPD, 2'h0, 32'h01);
		`CHK("div_upd2", 8'h03, div_a)
		`CHK("clkin_upd", 8'h1e, clkin_a)
		`CHK("pd_upd", PDSYNC_MASK, pd_a)
		wr(A_SETUP, 2'h0, 32'h18);
		lsb_mode = 1'b0;
		wr(A_SETUP, 2'h0, 32'h99);
		`CHK("two_pin_on", 1'b1, two_pin)
		rd_chk("two_pin_rd", A_DIV, 2'h0, 32'h03);
		wr(A_SETUP, 2'h0, 32'h18);
		// Soft reset holds until written back to zero
		wr(A_SETUP, 2'h0, 32'h3c);
		rd_chk("srst_held", A_SETUP, 2'h0, 32'h1c);
		rd_chk("srst_div", A_DIV, 2'h0, 32'h02);
		`CHK("srst_act", DIV_RST, div_a)
		`CHK("srst_clkin", CLKIN_RST, clkin_a)
		`CHK("srst_pd", PDSYNC_RST, pd_a)
		wr(A_SETUP, 2'h0, 32'h18);
		wr(A_DIV, 2'h0, 32'h06);
		rd_chk("srst_done", A_DIV, 2'h0, 32'h06);
		close_out();
	end
endmodule : tb_top
